// ===== verilog/i2cs_slave.sv
// Two-wire bus slave core with clock holds, receive buffering and sleep hooks
//
// Summary of operation
// - With address hold on, a matching write first address byte clears clock release, sets ack-time and interrupts.
// - Software setting clock release frees the clock line and clears the ack-time flag.
// - Each completed received data byte passes from the shift register through the FIFO into the receive buffer, setting buffer full.
// - Reading the receive buffer clears the buffer full flag.
// - A 10-bit read needs a repeated start and resent first byte with read set, then the slave holds the clock for data.
// - After a sent byte the slave holds the clock and interrupts on master ACK, and leaves it free on NACK.
// - Both clock and data inputs pass a glitch filter.
// - Slew limiting is active while control bit 9 is clear.
// - Setting control bit 8 selects SMBus input thresholds.
// - In sleep the slave keeps shifting, on external clock edges sampled by sys_clk.
// - The slave interrupts on an address match, a read hold or a master ACK after a sent byte; a match can wake the device when enabled.
// - Master transfers stop in sleep while register contents are kept.
`timescale 1ns/1ps
module i2cs_slave (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sclOut,
  output logic sclOe,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [9:0] ownAddress,
  input wire logic tenBitMode,
  input wire logic addressHoldEnable,
  input wire logic [15:0] controlBits,
  input wire logic acknowledgeDataValue,
  input wire logic clockReleaseSet,
  input wire logic slaveIrqClear,
  input wire logic slaveIrqEnable,
  input wire logic deviceSleep,
  input wire logic masterMode,
  input wire logic transmitWrite,
  input wire logic [7:0] transmitBuffer,
  input wire logic receiveRead,
  output logic clockReleaseBit,
  output logic acknowledgeTimeFlag,
  output logic slaveInterruptFlag,
  output logic wakeRequest,
  output logic masterHalted,
  output logic [7:0] receiveBuffer,
  output logic receiveBufferFullFlag,
  output logic slewLimitActive,
  output logic smbusLevels
);
  i2cs_stream_if rxStream ();
  i2cs_pkg::i2cs_state_t state_reg;
  i2cs_pkg::i2cs_kind_t kind_reg;
  logic [1:0] pinMeta_reg;
  logic [1:0] pinSync_reg;
  logic [1:0] filt_reg;
  logic [1:0] filtPrev_reg;
  logic [1:0] filtCnt_reg [2];
  logic [3:0] bitCnt_reg;
  logic [7:0] rxShift_reg;
  logic [7:0] txShift_reg;
  logic readMode_reg;
  logic tenMatched_reg;
  logic swAck_reg;
  logic masterAck_reg;
  logic pushPending_reg;
  logic [7:0] pushData_reg;
  logic clockRelease_next;
  logic sclRise, sclFall, startEv, stopEv;
  logic byteDone, a1Match, matchEv, holdAddr, ackFall, readHold, txAckHold, bufLoad;

  // First byte match: 7-bit compare, or 10-bit prefix with read allowed once matched
  function automatic logic firstByteMatch(input logic [7:0] b, input logic [9:0] adr,
                                          input logic ten, input logic tenDone);
    if (ten) begin
      firstByteMatch = (b[7:3] == i2cs_pkg::ADDR10_PREFIX) && (b[2:1] == adr[9:8]) &&
                       (!b[0] || tenDone);
    end else begin
      firstByteMatch = (b[7:1] == adr[6:0]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchroniser on both pins; only the second stage is read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_reg <= 2'h3;
      pinSync_reg <= 2'h3;
    end else begin
      pinMeta_reg <= {sdaIn, sclIn};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // Glitch filter: a level must persist before it is believed
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= 2'h3;
      filtPrev_reg <= 2'h3;
      filtCnt_reg[0] <= 2'h0;
      filtCnt_reg[1] <= 2'h0;
    end else begin
      filtPrev_reg <= filt_reg;
      for (int i = 0; i < 2; i++) begin
        if (pinSync_reg[i] == filt_reg[i]) begin
          filtCnt_reg[i] <= 2'h0;
        end else if (filtCnt_reg[i] == i2cs_pkg::FILT_LEN - 2'h1) begin
          filt_reg[i] <= pinSync_reg[i];
          filtCnt_reg[i] <= 2'h0;
        end else begin
          filtCnt_reg[i] <= filtCnt_reg[i] + 2'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus events and protocol decisions, all taken from the external clock
  always_comb begin
    sclRise = filt_reg[0] && !filtPrev_reg[0];
    sclFall = !filt_reg[0] && filtPrev_reg[0];
    startEv = filt_reg[0] && filtPrev_reg[0] && filtPrev_reg[1] && !filt_reg[1];
    stopEv = filt_reg[0] && filtPrev_reg[0] && !filtPrev_reg[1] && filt_reg[1];
    byteDone = (state_reg == i2cs_pkg::ST_RX) && sclFall &&
               (bitCnt_reg == i2cs_pkg::BITS_PER_BYTE);
    a1Match = firstByteMatch(rxShift_reg, ownAddress, tenBitMode, tenMatched_reg);
    matchEv = byteDone && (((kind_reg == i2cs_pkg::K_ADDR1) && a1Match) ||
              ((kind_reg == i2cs_pkg::K_ADDR2) && (rxShift_reg == ownAddress[7:0])));
    holdAddr = byteDone && (kind_reg == i2cs_pkg::K_ADDR1) && a1Match &&
               !rxShift_reg[0] && addressHoldEnable;
    ackFall = (state_reg == i2cs_pkg::ST_ACK) && sclFall;
    readHold = ackFall && readMode_reg && !(swAck_reg && acknowledgeDataValue);
    txAckHold = (state_reg == i2cs_pkg::ST_TXACK) && sclFall && masterAck_reg;
    clockRelease_next = clockReleaseBit;
    if (clockReleaseSet) begin
      clockRelease_next = 1'b1;
    end
    // Hardware hold wins over a software release in the same cycle
    if (holdAddr || readHold || txAckHold) begin
      clockRelease_next = 1'b0;
    end
  end

  // Protocol state machine
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= i2cs_pkg::ST_IDLE;
      kind_reg <= i2cs_pkg::K_ADDR1;
      bitCnt_reg <= 4'h0;
      rxShift_reg <= i2cs_pkg::BYTE_RST;
      readMode_reg <= i2cs_pkg::FLAG_RST;
      tenMatched_reg <= i2cs_pkg::FLAG_RST;
      swAck_reg <= i2cs_pkg::FLAG_RST;
      masterAck_reg <= i2cs_pkg::FLAG_RST;
    end else if (stopEv) begin
      state_reg <= i2cs_pkg::ST_IDLE;
      tenMatched_reg <= 1'b0;
    end else if (startEv) begin
      // Repeated start keeps a completed 10-bit match for the read redirect
      state_reg <= i2cs_pkg::ST_RX;
      kind_reg <= i2cs_pkg::K_ADDR1;
      bitCnt_reg <= 4'h0;
      readMode_reg <= 1'b0;
    end else begin
      case (state_reg)
        i2cs_pkg::ST_RX: begin
          if (sclRise) begin
            rxShift_reg <= {rxShift_reg[6:0], filt_reg[1]};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (byteDone) begin
            swAck_reg <= holdAddr;
            if (kind_reg == i2cs_pkg::K_DATA) begin
              state_reg <= i2cs_pkg::ST_ACK;
            end else if (!matchEv) begin
              state_reg <= i2cs_pkg::ST_IDLE;
            end else begin
              state_reg <= i2cs_pkg::ST_ACK;
              if (kind_reg == i2cs_pkg::K_ADDR2) begin
                tenMatched_reg <= 1'b1;
                kind_reg <= i2cs_pkg::K_DATA;
              end else if (rxShift_reg[0]) begin
                readMode_reg <= 1'b1;
              end else begin
                kind_reg <= tenBitMode ? i2cs_pkg::K_ADDR2 : i2cs_pkg::K_DATA;
              end
            end
          end
        end
        i2cs_pkg::ST_ACK: begin
          if (ackFall) begin
            bitCnt_reg <= 4'h0;
            if (swAck_reg && acknowledgeDataValue) begin
              state_reg <= i2cs_pkg::ST_IDLE;
            end else begin
              state_reg <= readMode_reg ? i2cs_pkg::ST_TX : i2cs_pkg::ST_RX;
            end
          end
        end
        i2cs_pkg::ST_TX: begin
          if (sclFall) begin
            bitCnt_reg <= bitCnt_reg + 4'h1;
            if (bitCnt_reg == i2cs_pkg::LAST_TX_FALL) begin
              state_reg <= i2cs_pkg::ST_TXACK;
            end
          end
        end
        i2cs_pkg::ST_TXACK: begin
          if (sclRise) begin
            masterAck_reg <= !filt_reg[1];
          end else if (sclFall) begin
            bitCnt_reg <= 4'h0;
            state_reg <= masterAck_reg ? i2cs_pkg::ST_TX : i2cs_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= i2cs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Transmit shifter: loaded by software during the hold, moved on each falling edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      txShift_reg <= i2cs_pkg::BYTE_RST;
    end else if (transmitWrite) begin
      txShift_reg <= transmitBuffer;
    end else if ((state_reg == i2cs_pkg::ST_TX) && sclFall) begin
      txShift_reg <= {txShift_reg[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Received data goes to the FIFO; a full FIFO stretches the clock instead of dropping
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pushPending_reg <= i2cs_pkg::FLAG_RST;
      pushData_reg <= i2cs_pkg::BYTE_RST;
    end else if (byteDone && (kind_reg == i2cs_pkg::K_DATA)) begin
      pushPending_reg <= 1'b1;
      pushData_reg <= rxShift_reg;
    end else if (rxStream.wReady) begin
      pushPending_reg <= 1'b0;
    end
  end

  assign rxStream.wValid = pushPending_reg;
  assign rxStream.wData = pushData_reg;
  assign bufLoad = rxStream.rValid && (!receiveBufferFullFlag || receiveRead);
  assign rxStream.rReady = bufLoad;

  i2cs_fifo #(
    .WIDTH(i2cs_pkg::DATA_W),
    .DEPTH(i2cs_pkg::FIFO_DEPTH)
  ) rxFifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .port(rxStream.fifo)
  );

  // Receive buffer and its full flag; a new byte arriving on a read keeps it set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      receiveBuffer <= i2cs_pkg::BYTE_RST;
      receiveBufferFullFlag <= i2cs_pkg::FLAG_RST;
    end else if (bufLoad) begin
      receiveBuffer <= rxStream.rData;
      receiveBufferFullFlag <= 1'b1;
    end else if (receiveRead) begin
      receiveBufferFullFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software-visible flags; hardware set wins over a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clockReleaseBit <= i2cs_pkg::CLK_REL_RST;
      acknowledgeTimeFlag <= i2cs_pkg::FLAG_RST;
      slaveInterruptFlag <= i2cs_pkg::FLAG_RST;
      wakeRequest <= i2cs_pkg::FLAG_RST;
    end else begin
      clockReleaseBit <= clockRelease_next;
      if (holdAddr) begin
        acknowledgeTimeFlag <= 1'b1;
      end else if (clockReleaseSet) begin
        acknowledgeTimeFlag <= 1'b0;
      end
      if (matchEv || readHold || txAckHold) begin
        slaveInterruptFlag <= 1'b1;
      end else if (slaveIrqClear) begin
        slaveInterruptFlag <= 1'b0;
      end
      wakeRequest <= matchEv && deviceSleep && slaveIrqEnable;
    end
  end

  // Pin drivers: clock held low while release is clear or a received byte waits on a full FIFO
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
      sclOe <= 1'b0;
      sdaOe <= 1'b0;
    end else begin
      sclOe <= !clockRelease_next || (pushPending_reg && !rxStream.wReady);
      // Data line is decided on the clock fall itself; one cycle later would move it past
      // the master's next rise, and the filters would read that as a start or a stop
      if (byteDone) begin
        sdaOe <= ((kind_reg == i2cs_pkg::K_DATA) || matchEv) &&
                 !(holdAddr && acknowledgeDataValue);
      end else if ((state_reg == i2cs_pkg::ST_TX) && sclFall) begin
        sdaOe <= (bitCnt_reg != i2cs_pkg::LAST_TX_FALL) && !txShift_reg[6];
      end else if (sclFall) begin
        sdaOe <= 1'b0;
      end else begin
        case (state_reg)
          i2cs_pkg::ST_ACK: sdaOe <= !(swAck_reg && acknowledgeDataValue);
          i2cs_pkg::ST_TX: sdaOe <= !txShift_reg[7];
          default: sdaOe <= 1'b0;
        endcase
      end
    end
  end

  // Static pad controls and the sleep halt for master transfers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slewLimitActive <= 1'b1;
      smbusLevels <= 1'b0;
      masterHalted <= 1'b0;
    end else begin
      slewLimitActive <= !controlBits[i2cs_pkg::SLEW_DIS_BIT];
      smbusLevels <= controlBits[i2cs_pkg::SMBUS_SEL_BIT];
      // Halt only; no state is cleared so contents survive sleep
      masterHalted <= masterMode && deviceSleep;
    end
  end
endmodule // i2cs_slave

// ===== verilog/i2cs_pkg.sv
// Shared constants and types of the two-wire bus slave
package i2cs_pkg;
  // Byte and buffer geometry
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_TX_FALL = 4'h7;
  // Glitch filter: samples an input must hold before the filtered level follows
  localparam logic [1:0] FILT_LEN = 2'h2;
  // Field positions in the control word
  localparam int SLEW_DIS_BIT = 9;
  localparam int SMBUS_SEL_BIT = 8;
  // First byte of a 10-bit address carries this prefix
  localparam logic [4:0] ADDR10_PREFIX = 5'h1e;
  // Reset values
  localparam logic CLK_REL_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Protocol states and byte kinds
  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK} i2cs_state_t;
  typedef enum logic [1:0] {K_ADDR1, K_ADDR2, K_DATA} i2cs_kind_t;
endpackage

// ===== verilog/i2cs_stream_if.sv
// Valid/ready stream carrier between the slave core and its receive FIFO
`timescale 1ns/1ps
interface i2cs_stream_if;
  logic [i2cs_pkg::DATA_W-1:0] wData;
  logic wValid;
  logic wReady;
  logic [i2cs_pkg::DATA_W-1:0] rData;
  logic rValid;
  logic rReady;
  modport fifo (input wData, input wValid, output wReady,
                output rData, output rValid, input rReady);
  modport user (output wData, output wValid, input wReady,
                input rData, input rValid, output rReady);
endinterface

// ===== verilog/i2cs_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module i2cs_fifo #(
  parameter int WIDTH = i2cs_pkg::DATA_W,
  parameter int DEPTH = i2cs_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  i2cs_stream_if.fifo port
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doWrite;
  logic doRead;

  // Honest full and empty come straight from the occupancy count
  assign port.wReady = (count_reg != (AW+1)'(DEPTH));
  assign port.rValid = (count_reg != '0);
  assign port.rData = mem[rdPtr_reg];
  assign doWrite = port.wValid && port.wReady;
  assign doRead = port.rValid && port.rReady;

  ////////////////////////////////////////////////////////////////////////
  // Storage array, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= port.wData;
    end
  end

  // Pointers and count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (doRead) begin
        rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + 1'b1;
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // i2cs_fifo

// ===== testbench/i2cs_slave_checker.sv
// Concurrent checks on the ports of the two-wire bus slave
`timescale 1ns/1ps
module i2cs_slave_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] controlBits,
  input wire logic clockReleaseSet,
  input wire logic masterMode,
  input wire logic deviceSleep,
  input wire logic receiveRead,
  input logic sclOe,
  input logic sdaOe,
  input logic clockReleaseBit,
  input logic acknowledgeTimeFlag,
  input logic slaveInterruptFlag,
  input logic masterHalted,
  input logic [7:0] receiveBuffer,
  input logic receiveBufferFullFlag,
  input logic slewLimitActive,
  input logic smbusLevels
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock holds and their release
  property p_addr_hold;
    $rose(acknowledgeTimeFlag) |-> !clockReleaseBit ##1 sclOe && slaveInterruptFlag;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address hold missing");
  property p_release;
    clockReleaseSet && acknowledgeTimeFlag |=> clockReleaseBit && !acknowledgeTimeFlag;
  endproperty
  a_release: assert property (p_release) else $error("release did not end hold");
  // A held clock needs a cleared release bit or a backed-up buffer behind it
  property p_hold_cause;
    sclOe |-> !clockReleaseBit || !$past(clockReleaseBit) || receiveBufferFullFlag;
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("clock held without cause");
  property p_irq_cause;
    $rose(slaveInterruptFlag) |-> ##[0:2] (sdaOe || sclOe);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without match");
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Receive buffer; a same-valued follow-on byte arriving on the read would falsely trip this one
  property p_read_clear;
    receiveRead && receiveBufferFullFlag |=> !receiveBufferFullFlag || $changed(receiveBuffer);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read left buffer full");
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pin conditioning and sleep status follow their controls after one cycle
  property p_slew;
    1'b1 |=> slewLimitActive == !$past(controlBits[9]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew limit wrong");
  property p_smbus;
    $changed(controlBits[8]) |=> smbusLevels == $past(controlBits[8]);
  endproperty
  a_smbus: assert property (p_smbus) else $error("input level select wrong");
  property p_halt;
    1'b1 |=> masterHalted == ($past(masterMode) && $past(deviceSleep));
  endproperty
  a_halt: assert property (p_halt) else $error("master halt wrong");
endmodule // i2cs_slave_checker

bind i2cs_slave i2cs_slave_checker i_chk (.sys_clk, .rst_n, .controlBits, .clockReleaseSet,
  .masterMode, .deviceSleep, .receiveRead, .sclOe, .sdaOe, .clockReleaseBit,
  .acknowledgeTimeFlag, .slaveInterruptFlag, .masterHalted, .receiveBuffer,
  .receiveBufferFullFlag, .slewLimitActive, .smbusLevels);

// ===== testbench/i2cs_master_model.sv
// Behavioural bus master driving the slave's clock and data pins
`timescale 1ns/1ps
module i2cs_master_model (
  input wire logic sclLine,
  input wire logic sdaLine,
  output logic mScl,
  output logic mSda
);
  int glitchAt = -1;
  int bitNo = 0;
  // Released lines float to the pull-up level
  initial begin
    mScl = 1'b1;
    mSda = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Raise the clock and wait out any hold; bounded so a stuck slave cannot hang us
  task stretch();
    int n;
    n = 0;
    mScl = 1'b1;
    while (sclLine !== 1'b1 && n < 4000) begin
      #100;
      n++;
    end
  endtask
  // Start or repeated start; a read of a 10-bit slave comes after a repeated start
  task start();
    bitNo = 0;
    // Land every pin change but the spike edges a quarter period off the sampling edge, so none races it
    #(475 - ($time % 100)) mSda = 1'b1;
    #100 stretch();
    #400 mSda = 1'b0;
    #400 mScl = 1'b0;
  endtask
  // Long low phase: the slave lets go of the data line about 500 ns after a fall
  task bit_out(input logic b);
    #450 mSda = b;
    if (bitNo == glitchAt) begin
      #20 mScl = 1'b1;
      #60 mScl = 1'b0;
      #20;
    end else begin
      #100;
    end
    stretch();
    #250 mScl = 1'b0;
    bitNo++;
  endtask
  task bit_in(output logic b);
    #450 mSda = 1'b1;
    #100 stretch();
    #150 b = sdaLine;
    #100 mScl = 1'b0;
  endtask
  task send_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask
  task recv_byte(input logic nack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(nack);
  endtask
  task stop();
    #450 mSda = 1'b0;
    #100 stretch();
    #400 mSda = 1'b1;
    #400;
  endtask
endmodule // i2cs_master_model

// ===== testbench/tb_i2cs_slave.sv
// Self-checking bench for the two-wire bus slave
`timescale 1ns/1ps
module tb_i2cs_slave;
  logic sys_clk, rst_n, tenBitMode, addressHoldEnable, acknowledgeDataValue, clockReleaseSet;
  logic slaveIrqClear, slaveIrqEnable, deviceSleep, masterMode, transmitWrite, receiveRead;
  logic [9:0] ownAddress;
  logic [15:0] controlBits;
  logic [7:0] transmitBuffer, receiveBuffer, d1, d2;
  logic sclOut, sclOe, sdaOut, sdaOe, clockReleaseBit, acknowledgeTimeFlag, slaveInterruptFlag;
  logic wakeRequest, masterHalted, receiveBufferFullFlag, slewLimitActive, smbusLevels;
  logic mScl, mSda, ack, ack2, ack3, wakeSeen;
  wire logic sclIn;
  wire logic sdaIn;
  int bad_count = 0;
  int comparisons = 0;
  // Wired-AND bus: a line is low when either party pulls it
  assign sclIn = mScl & ~sclOe;
  assign sdaIn = mSda & ~sdaOe;
  i2cs_slave i_dut (.sys_clk, .rst_n, .sclIn, .sdaIn, .sclOut, .sclOe, .sdaOut, .sdaOe,
    .ownAddress, .tenBitMode, .addressHoldEnable, .controlBits, .acknowledgeDataValue,
    .clockReleaseSet, .slaveIrqClear, .slaveIrqEnable, .deviceSleep, .masterMode,
    .transmitWrite, .transmitBuffer, .receiveRead, .clockReleaseBit, .acknowledgeTimeFlag,
    .slaveInterruptFlag, .wakeRequest, .masterHalted, .receiveBuffer, .receiveBufferFullFlag,
    .slewLimitActive, .smbusLevels);
  i2cs_master_model i_master (.sclLine(sclIn), .sdaLine(sdaIn), .mScl, .mSda);
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Clock and wake pulse catcher; the pulse lasts one cycle only
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (wakeRequest === 1'b1) wakeSeen <= 1'b1;
  ////////////////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  // Checks happen at a falling edge so the rising-edge updates have landed
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // One-cycle software strobe: 0 release, 1 read, 2 transmit load, 3 irq clear
  task pulse(input int k);
    @(posedge sys_clk);
    case (k)
      0: clockReleaseSet <= 1'b1;
      1: receiveRead <= 1'b1;
      2: transmitWrite <= 1'b1;
      default: slaveIrqClear <= 1'b1;
    endcase
    @(posedge sys_clk);
    {clockReleaseSet, receiveRead, transmitWrite, slaveIrqClear} <= 4'h0;
    settle(0);
  endtask
  task wait_hold();
    int n;
    n = 0;
    while (sclOe !== 1'b1 && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    settle(1);
  endtask
  task report_and_stop();
    if (bad_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////////
  // Watchdog: the tests need about a thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("CHECK FAILED at %0t: timeout", $time);
    report_and_stop();
  end
  // Main sequence
  initial begin
    {rst_n, tenBitMode, addressHoldEnable, acknowledgeDataValue, clockReleaseSet} = 5'h00;
    {slaveIrqClear, deviceSleep, masterMode, transmitWrite, receiveRead} = 5'h00;
    {controlBits, transmitBuffer, wakeSeen} = 25'h0;
    slaveIrqEnable = 1'b1;
    ownAddress = 10'h05a;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    settle(6);
    chk(clockReleaseBit, 8'h01, "release reset");
    chk(receiveBufferFullFlag, 8'h00, "full reset");
    chk({sclOut, sdaOut}, 8'h00, "open drain levels");
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk) controlBits <= {6'h00, k[1:0], 8'h00};
      settle(2);
      chk(slewLimitActive, {7'h00, ~k[1]}, "slew");
      chk(smbusLevels, {7'h00, k[0]}, "levels");
    end
    // Sleep in master mode only while no master transfer is running
    @(posedge sys_clk) {masterMode, deviceSleep} <= 2'h3;
    settle(2);
    chk(masterHalted, 8'h01, "halt");
    @(posedge sys_clk) {masterMode, deviceSleep} <= 2'h0;
    i_master.start();
    i_master.send_byte(8'hb6, ack);
    i_master.stop();
    chk(ack, 8'h00, "foreign address");
    chk(slaveInterruptFlag, 8'h00, "foreign irq");
    // Write while asleep, with a short clock spike inside the address byte
    @(posedge sys_clk) deviceSleep <= 1'b1;
    i_master.glitchAt = 3;
    i_master.start();
    i_master.send_byte(8'hb4, ack);
    i_master.glitchAt = -1;
    i_master.send_byte(8'ha5, ack2);
    i_master.stop();
    chk(ack, 8'h01, "spike filtered");
    chk(wakeSeen, 8'h01, "wake");
    chk(receiveBuffer, 8'ha5, "asleep data");
    chk(receiveBufferFullFlag, 8'h01, "full set");
    pulse(1);
    chk(receiveBufferFullFlag, 8'h00, "full clear");
    pulse(3);
    @(posedge sys_clk) {deviceSleep, addressHoldEnable} <= 2'h1;
    fork
      begin
        i_master.start();
        i_master.send_byte(8'hb4, ack);
        i_master.send_byte(8'h3c, ack2);
        i_master.stop();
      end
      begin
        wait_hold();
        chk(acknowledgeTimeFlag, 8'h01, "ack time");
        chk({clockReleaseBit, slaveInterruptFlag}, 8'h01, "hold flags");
        pulse(0);
        chk({clockReleaseBit, acknowledgeTimeFlag}, 8'h02, "released");
      end
    join
    chk({ack, ack2}, 8'h03, "held write acked");
    chk(receiveBuffer, 8'h3c, "held write data");
    pulse(1);
    pulse(3);
    @(posedge sys_clk) {tenBitMode, addressHoldEnable, ownAddress} <= {2'h2, 10'h2b5};
    fork
      begin
        i_master.start();
        i_master.send_byte({i2cs_pkg::ADDR10_PREFIX, 2'h2, 1'b0}, ack);
        i_master.send_byte(8'hb5, ack2);
        i_master.start();
        i_master.send_byte({i2cs_pkg::ADDR10_PREFIX, 2'h2, 1'b1}, ack3);
        i_master.recv_byte(1'b0, d1);
        i_master.recv_byte(1'b1, d2);
        i_master.stop();
      end
      begin
        for (int k = 0; k < 2; k++) begin
          wait_hold();
          chk(slaveInterruptFlag, 8'h01, "read hold irq");
          @(posedge sys_clk) transmitBuffer <= k ? 8'hc3 : 8'h3c;
          pulse(2);
          pulse(3);
          pulse(0);
        end
      end
    join
    chk({ack, ack2, ack3}, 8'h07, "10-bit read acks");
    chk(d1, 8'h3c, "first sent byte");
    chk(d2, 8'hc3, "second sent byte");
    settle(3);
    chk({sclOe, slaveInterruptFlag}, 8'h00, "no hold after nack");
    // Held address answered with NACK by software before the release
    @(posedge sys_clk) {tenBitMode, addressHoldEnable, ownAddress} <= {2'h1, 10'h05a};
    fork
      begin
        i_master.start();
        i_master.send_byte(8'hb4, ack);
        i_master.stop();
      end
      begin
        wait_hold();
        @(posedge sys_clk) acknowledgeDataValue <= 1'b1;
        pulse(0);
      end
    join
    chk({ack, sdaOe, sclOe}, 8'h00, "held address refused");
    report_and_stop();
  end
endmodule // tb_i2cs_slave
